//--- core/swc_cfg.svh
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// ----------------------------------------
// feature current field positions
// ----------------------------------------
`define SWC_URG_BIT 7
`define SWC_WC_BIT 6
`define SWC_FLUSH_BIT 5
`define SWC_HSE_BIT 4
`define SWC_SID_MSB 2
// ----------------------------------------
// command, status and error bits
// ----------------------------------------
`define SWC_CMD_CODE 8'h3B
`define SWC_ST_BSY 7
`define SWC_ST_RDY 6
`define SWC_ST_SE 5
`define SWC_ST_ERR 0
`define SWC_ER_IDNF 4
`define SWC_ER_ABRT 2
`define SWC_ER_TIME_LIMIT_EXCEEDED_FLAG 0
// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define SWC_CLK_MHZ 25
`define SWC_US_CYC 25
`define SWC_MIN_COMPLETION_TIME_LIMIT_US 32'h0000_03E8
`define SWC_STREAMS 8
`define SWC_FIFO_DEPTH 8
`endif

//--- core/swc_pkg.sv
package swc_pkg;
  typedef enum logic [4:0] {
    SWC_IDLE  = 5'h01,
    SWC_XFER  = 5'h02,
    SWC_FLUSH = 5'h04,
    SWC_DONE  = 5'h08,
    SWC_ABORT = 5'h10
  } swc_state_t;
  typedef logic [2:0] swc_sid_t;
endpackage : swc_pkg

//--- core/swc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module swc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic in_valid_in, // write valid
  output logic in_ready_out, // not full
  input wire logic [WIDTH-1:0] in_data_in, // write data
  output logic out_valid_out, // not empty
  input wire logic out_ready_in, // read ready
  output logic [WIDTH-1:0] out_data_out // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready_out = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_out = (cnt_reg != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_reg[rd_reg];
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : swc_fifo
`default_nettype wire

//--- core/swc_ctrl.sv
`include "swc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module swc_ctrl (
  input wire logic clock_in, // 25 MHz clock
  input wire logic rst_in, // sync reset, high
  input wire logic cmd_write_in, // command register write strobe
  input wire logic [7:0] cmd_code_in, // command register value
  input wire logic [7:0] stream_write_options_in, // feature current
  input wire logic [7:0] completion_time_multiplier_in, // feature previous
  input wire logic [15:0] sector_count_in, // sector count, 0 = 65536
  input wire logic [47:0] start_lba_in, // starting block address
  input wire logic [31:0] timing_unit_in, // identify words 99:98, us
  input wire logic cfg_write_in, // stream configuration strobe
  input wire swc_pkg::swc_sid_t cfg_sid_in, // configured stream
  input wire logic [15:0] cfg_default_in, // default limit multiplier
  input wire logic high_order_byte_select_in, // selects upper lba bytes
  input wire logic xfer_valid_in, // host sector data valid
  output logic xfer_ready_out, // sector accepted
  input wire logic [15:0] xfer_data_in, // sector word
  input wire logic xfer_err_in, // transfer error on this word
  output logic media_valid_out, // word to media
  input wire logic media_ready_in, // media accepts word
  output logic [15:0] media_data_out, // media word
  input wire logic media_err_in, // media write error, pulse
  input wire logic flush_done_in, // media committed stream data
  output logic flush_req_out, // commit buffered stream data
  output var swc_pkg::swc_sid_t media_sid_out, // stream in use
  output logic resume_recovery_out, // resume earlier recovery
  output logic urgent_out, // urgent priority hint
  output logic [7:0] status_out, // ending status
  output logic [7:0] error_out, // error log
  output logic [7:0] lba_lo_out, // sector number
  output logic [7:0] lba_mid_out, // cylinder low
  output logic [7:0] lba_hi_out, // cylinder high
  output logic intrq_out // completion interrupt, pulse
);
  import swc_pkg::*;
  swc_state_t state_reg;
  logic [7:0] opts_reg;
  logic [16:0] left_reg;
  logic [47:0] cur_lba_reg;
  logic [47:0] err_lba_reg;
  logic err_seen_reg;
  logic [15:0] dflt_reg [`SWC_STREAMS];
  logic [`SWC_STREAMS-1:0] cfgd_reg;
  logic [47:0] limit_reg;
  logic limit_on_reg;
  logic [47:0] elapsed_reg;
  logic [4:0] us_reg;
  logic fifo_in_ready;
  logic fifo_push;
  logic start;
  logic expired;
  logic any_err;
  logic [47:0] req_us;
  logic [47:0] lim_us;
  logic [15:0] mult;

  function automatic logic [47:0] calc_us(input logic [15:0] m,
                                          input logic [31:0] unit);
    calc_us = 48'(m) * 48'(unit);
  endfunction : calc_us

  assign start = cmd_write_in && (cmd_code_in == `SWC_CMD_CODE)
                 && (state_reg == SWC_IDLE);
  assign any_err = (fifo_push && xfer_err_in) || media_err_in;
  assign expired = limit_on_reg && (elapsed_reg >= limit_reg);
  // ----------------------------------------
  // time limit selection
  // ----------------------------------------
  always_comb begin
    mult = 16'(completion_time_multiplier_in);
    if (completion_time_multiplier_in == 8'h00) begin
      mult = dflt_reg[stream_write_options_in[`SWC_SID_MSB:0]];
    end
    req_us = calc_us(mult, timing_unit_in);
    lim_us = (req_us < 48'(`SWC_MIN_COMPLETION_TIME_LIMIT_US)) ?
             48'(`SWC_MIN_COMPLETION_TIME_LIMIT_US) : req_us;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfgd_reg <= '0;
      for (int i = 0; i < `SWC_STREAMS; i++) begin
        dflt_reg[i] <= 16'h0000;
      end
    end else if (cfg_write_in) begin
      cfgd_reg[cfg_sid_in] <= 1'b1;
      dflt_reg[cfg_sid_in] <= cfg_default_in;
    end
  end
  // ----------------------------------------
  // command state machine
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= SWC_IDLE;
    end else begin
      case (state_reg)
        SWC_IDLE: begin
          if (start) begin
            state_reg <= SWC_XFER;
          end
        end
        SWC_XFER: begin
          if (expired) begin
            state_reg <= SWC_ABORT;
          end else if (any_err && !opts_reg[`SWC_WC_BIT]) begin
            state_reg <= SWC_ABORT;
          end else if (left_reg == 17'h00000 && !media_valid_out) begin
            state_reg <= opts_reg[`SWC_FLUSH_BIT] ? SWC_FLUSH : SWC_DONE;
          end
        end
        SWC_FLUSH: begin
          if (expired) begin
            state_reg <= SWC_ABORT;
          end else if (flush_done_in) begin
            state_reg <= SWC_DONE;
          end
        end
        SWC_DONE: state_reg <= SWC_IDLE;
        SWC_ABORT: state_reg <= SWC_IDLE;
        default: state_reg <= SWC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      opts_reg <= 8'h00;
      limit_reg <= '0;
      limit_on_reg <= 1'b0;
    end else if (start) begin
      opts_reg <= stream_write_options_in;
      limit_reg <= lim_us;
      limit_on_reg <= (completion_time_multiplier_in != 8'h00) ||
        (cfgd_reg[stream_write_options_in[`SWC_SID_MSB:0]] &&
         mult != 16'h0000);
    end
  end
  // ----------------------------------------
  // elapsed time, microseconds
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in || start) begin
      us_reg <= 5'h00;
      elapsed_reg <= '0;
    end else if (state_reg != SWC_IDLE) begin
      if (us_reg == 5'(`SWC_US_CYC - 1)) begin
        us_reg <= 5'h00;
        elapsed_reg <= elapsed_reg + 48'h1;
      end else begin
        us_reg <= us_reg + 5'h01;
      end
    end
  end
  // ----------------------------------------
  // data path and sector count
  // ----------------------------------------
  // one word counts as one sector unit; errors do not stop intake under WC
  assign fifo_push = xfer_valid_in && fifo_in_ready &&
                     (state_reg == SWC_XFER) && (left_reg != 17'h00000);
  assign xfer_ready_out = fifo_push;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      left_reg <= 17'h00000;
      cur_lba_reg <= '0;
    end else if (start) begin
      left_reg <= (sector_count_in == 16'h0000) ? 17'h10000 :
                  {1'b0, sector_count_in};
      cur_lba_reg <= start_lba_in;
    end else if (fifo_push) begin
      left_reg <= left_reg - 17'h00001;
      cur_lba_reg <= cur_lba_reg + 48'h1;
    end
  end

  swc_fifo #(.WIDTH(16), .DEPTH(`SWC_FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(xfer_data_in),
    .out_valid_out(media_valid_out),
    .out_ready_in(media_ready_in),
    .out_data_out(media_data_out)
  );
  // ----------------------------------------
  // ending status and error log
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in || start) begin
      err_seen_reg <= 1'b0;
      err_lba_reg <= '0;
      error_out <= 8'h00;
    end else if (state_reg == SWC_XFER) begin
      if (any_err && !err_seen_reg) begin
        err_seen_reg <= 1'b1;
        err_lba_reg <= cur_lba_reg;
      end
      if (fifo_push && xfer_err_in) begin
        error_out[`SWC_ER_ABRT] <= 1'b1;
      end
      if (media_err_in) begin
        error_out[`SWC_ER_IDNF] <= 1'b1;
      end
      if (expired) begin
        error_out[`SWC_ER_TIME_LIMIT_EXCEEDED_FLAG] <= 1'b1;
      end
    end else if (state_reg == SWC_FLUSH && expired) begin
      error_out[`SWC_ER_TIME_LIMIT_EXCEEDED_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      status_out <= 8'h40;
      intrq_out <= 1'b0;
    end else begin
      intrq_out <= 1'b0;
      if (start) begin
        status_out <= 8'h80;
      end else if (state_reg == SWC_DONE || state_reg == SWC_ABORT) begin
        intrq_out <= 1'b1;
        status_out <= 8'h40;
        if (error_out != 8'h00 || err_seen_reg) begin
          if (opts_reg[`SWC_WC_BIT]) begin
            status_out[`SWC_ST_SE] <= 1'b1;
          end else begin
            status_out[`SWC_ST_ERR] <= 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    lba_lo_out = high_order_byte_select_in ? err_lba_reg[31:24] :
                 err_lba_reg[7:0];
    lba_mid_out = high_order_byte_select_in ? err_lba_reg[39:32] :
                  err_lba_reg[15:8];
    lba_hi_out = high_order_byte_select_in ? err_lba_reg[47:40] :
                 err_lba_reg[23:16];
  end

  assign flush_req_out = (state_reg == SWC_FLUSH);
  assign media_sid_out = opts_reg[`SWC_SID_MSB:0];
  assign resume_recovery_out = opts_reg[`SWC_HSE_BIT] &&
                               (state_reg != SWC_IDLE);
  assign urgent_out = opts_reg[`SWC_URG_BIT] &&
                      (state_reg != SWC_IDLE);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_expire_stops;
    @(posedge clock_in) disable iff (rst_in)
    (state_reg == SWC_XFER && expired) |=> state_reg == SWC_ABORT;
  endproperty
  a_expire_stops: assert property (p_expire_stops)
    else $error("limit expiry did not stop command");
  property p_wc_no_abort;
    @(posedge clock_in) disable iff (rst_in)
    (state_reg == SWC_XFER && opts_reg[`SWC_WC_BIT] && !expired && any_err)
    |=> state_reg != SWC_ABORT;
  endproperty
  a_wc_no_abort: assert property (p_wc_no_abort)
    else $error("continuous write aborted on error");
  property p_nowc_abort;
    @(posedge clock_in) disable iff (rst_in)
    (state_reg == SWC_XFER && !opts_reg[`SWC_WC_BIT] && any_err)
    |=> state_reg == SWC_ABORT ##1 status_out[`SWC_ST_ERR];
  endproperty
  a_nowc_abort: assert property (p_nowc_abort)
    else $error("error without continuous write not reported");
  property p_wc_status;
    @(posedge clock_in) disable iff (rst_in)
    (intrq_out && opts_reg[`SWC_WC_BIT] && error_out != 8'h00)
    |-> status_out[`SWC_ST_SE] && !status_out[`SWC_ST_ERR]
        && !status_out[`SWC_ST_BSY];
  endproperty
  a_wc_status: assert property (p_wc_status)
    else $error("continuous write ending status wrong");
  property p_zero_count;
    @(posedge clock_in) disable iff (rst_in)
    (start && sector_count_in == 16'h0000) |=> left_reg == 17'h10000;
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("zero sector count not 65536");
  property p_min_limit;
    @(posedge clock_in) disable iff (rst_in)
    start |=> limit_reg >= 48'(`SWC_MIN_COMPLETION_TIME_LIMIT_US);
  endproperty
  a_min_limit: assert property (p_min_limit)
    else $error("limit below minimum");
  property p_no_limit;
    @(posedge clock_in) disable iff (rst_in)
    (start && completion_time_multiplier_in == 8'h00 &&
     !cfgd_reg[stream_write_options_in[`SWC_SID_MSB:0]]) |=> !limit_on_reg;
  endproperty
  a_no_limit: assert property (p_no_limit)
    else $error("unconfigured stream got a time limit");
  // expiry under continuous write: abort state, then the ending report
  sequence s_wc_expire;
    state_reg == SWC_XFER && expired && opts_reg[`SWC_WC_BIT];
  endsequence
  sequence s_wc_expire_end;
    intrq_out && status_out[`SWC_ST_SE] && !status_out[`SWC_ST_ERR] &&
    error_out[`SWC_ER_TIME_LIMIT_EXCEEDED_FLAG];
  endsequence
  property p_wc_expire;
    @(posedge clock_in) disable iff (rst_in)
    s_wc_expire |=> ##1 s_wc_expire_end;
  endproperty
  a_wc_expire: assert property (p_wc_expire)
    else $error("expiry under continuous write misreported");
  sequence s_flush_wait;
    state_reg == SWC_FLUSH && !flush_done_in && !expired;
  endsequence
  property p_flush_hold;
    @(posedge clock_in) disable iff (rst_in)
    s_flush_wait |=> !intrq_out;
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("completion before flush");
  property p_hob;
    @(posedge clock_in) disable iff (rst_in)
    high_order_byte_select_in |-> lba_hi_out == err_lba_reg[47:40];
  endproperty
  a_hob: assert property (p_hob)
    else $error("high order byte mismatch");
endmodule : swc_ctrl
`default_nettype wire

//--- sim/swc_media_model.sv
`timescale 1ns/1ps
`default_nettype none
module swc_media_model (
  input wire logic clock_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic media_valid_in, // word offered by the block
  output logic media_ready_out, // media accepts word
  output logic media_err_out, // one-cycle write error
  input wire logic err_arm_in, // bench asks for one error
  input wire logic flush_req_in, // commit request level
  output logic flush_done_out // commit finished pulse
);
  logic fired_reg;
  logic [4:0] fl_cnt_reg;
  // ----------------------------------------
  // media acceptance, stalls one cycle in four
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      media_ready_out <= 1'b0;
    end else begin
      media_ready_out <= ($urandom % 4) != 0;
    end
  end
  // ----------------------------------------
  // one error per arming, on a real handshake
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in || !err_arm_in) begin
      fired_reg <= 1'b0;
      media_err_out <= 1'b0;
    end else begin
      media_err_out <= !fired_reg && media_valid_in && media_ready_out;
      if (media_valid_in && media_ready_out) fired_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // commit takes 20 cycles, slow enough to be seen
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in || !flush_req_in) begin
      fl_cnt_reg <= 5'h00;
      flush_done_out <= 1'b0;
    end else begin
      if (fl_cnt_reg != 5'h1F) fl_cnt_reg <= fl_cnt_reg + 5'h01;
      flush_done_out <= fl_cnt_reg == 5'h13;
    end
  end
endmodule : swc_media_model
`default_nettype wire

//--- sim/swc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swc_ctrl_tb;
  import swc_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, cmd_write_in = 1'b0;
  logic [7:0] cmd_code_in = 8'h3B, stream_write_options_in = '0;
  logic [7:0] completion_time_multiplier_in = '0;
  logic [15:0] sector_count_in = '0, cfg_default_in = '0, xfer_data_in = '0;
  logic [47:0] start_lba_in = '0, lba = '0;
  logic [31:0] timing_unit_in = 32'h0000_04B0;
  logic cfg_write_in = 1'b0, high_order_byte_select_in = 1'b0;
  logic xfer_valid_in = 1'b0, xfer_err_in = 1'b0, err_arm = 1'b0;
  swc_sid_t cfg_sid_in = '0, media_sid_out;
  logic xfer_ready_out, media_valid_out, media_ready_in, media_err_in;
  logic [15:0] media_data_out;
  logic flush_done_in, flush_req_out, resume_recovery_out, urgent_out;
  logic [7:0] status_out, error_out, lba_lo_out, lba_mid_out, lba_hi_out;
  logic intrq_out;
  int errors = 0, comparisons = 0, cyc = 0, t0 = 0, t1 = 0, tfl = 0;
  int ndone = 0, gap = 0, span = 0;
  logic [23:0] eb;
  logic [15:0] exp_q[$];
  logic [15:0] mq[$];
  bit mchk = 1'b0;

  swc_ctrl u_dut (.*);
  swc_media_model u_media (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .media_valid_in(media_valid_out),
    .media_ready_out(media_ready_in),
    .media_err_out(media_err_in),
    .err_arm_in(err_arm),
    .flush_req_in(flush_req_out),
    .flush_done_out(flush_done_in)
  );

  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;
  assign eb = {lba_hi_out, lba_mid_out, lba_lo_out};

  task automatic chk(string n, logic [47:0] s, logic [47:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // result watcher: oldest note against what appears
  // ----------------------------------------
  always @(negedge clock_in) begin
    if (flush_done_in === 1'b1) tfl = cyc;
    if (intrq_out === 1'b1) begin
      t1 = cyc;
      ndone++;
      if (exp_q.size() > 0) begin
        chk("ending", {status_out, error_out}, exp_q.pop_front());
      end else begin
        chk("spurious intrq", 1'b1, 1'b0);
      end
    end
    if (mchk && media_valid_out === 1'b1 && media_ready_in === 1'b1
        && mq.size() > 0) begin
      chk("media word", media_data_out, mq.pop_front());
    end
  end

  // cnt goes to the block, sent words are offered, ew marks the bad one
  task automatic run(input logic [7:0] o, m, input logic [15:0] cnt,
                     input int sent, ew, input logic [15:0] ex);
    int w;
    int acc;
    int nd;
    acc = 0;
    nd = ndone;
    @(posedge clock_in);
    #1;
    stream_write_options_in = o;
    completion_time_multiplier_in = m;
    sector_count_in = cnt;
    start_lba_in = lba;
    cmd_write_in = 1'b1;
    exp_q.push_back(ex);
    mq.delete();
    t0 = cyc;
    @(posedge clock_in);
    #1;
    cmd_write_in = 1'b0;
    @(negedge clock_in);
    chk("hints", {urgent_out, resume_recovery_out, media_sid_out},
        {o[7], o[4], o[2:0]});
    chk("busy", status_out, 8'h80);
    @(posedge clock_in);
    #1;
    for (int i = 0; i < sent; i++) begin
      xfer_valid_in = 1'b1;
      xfer_data_in = 16'($urandom);
      xfer_err_in = (i == ew);
      w = 0;
      do begin
        @(negedge clock_in);
        w++;
      end while (xfer_ready_out !== 1'b1 && w < 300);
      if (xfer_ready_out !== 1'b1) break;
      mq.push_back(xfer_data_in);
      acc++;
      @(posedge clock_in);
      #1;
      if (i == 0 && gap > 0) begin
        xfer_valid_in = 1'b0;
        repeat (gap) @(posedge clock_in);
        #1;
      end
    end
    if (acc == int'(cnt)) begin
      @(negedge clock_in);
      chk("excess word", xfer_ready_out, 1'b0);
      @(posedge clock_in);
      #1;
    end
    xfer_valid_in = 1'b0;
    xfer_err_in = 1'b0;
    w = 0;
    while (ndone == nd && w < 40000) begin
      @(negedge clock_in);
      w++;
    end
    chk("completion", 1'(ndone != nd), 1'b1);
  endtask : run

  initial begin
    void'($urandom(32'hABAB43B6));
    repeat (4) @(posedge clock_in);
    #1;
    rst_in = 1'b0;
    chk("reset", {status_out, error_out}, 16'h4000);
    cfg_write_in = 1'b1;
    cfg_sid_in = 3'h3;
    cfg_default_in = 16'h0001;
    @(posedge clock_in);
    #1;
    cfg_write_in = 1'b0;
    mchk = 1'b1;
    lba = 48'h1234_5678_9ABC;
    run(8'h02, 8'h40, 16'h0006, 6, -1, 16'h4000);
    run(8'h25, 8'h40, 16'h0004, 4, -1, 16'h4000);
    chk("flush first", 1'(tfl > t0 && t1 > tfl), 1'b1);
    mchk = 1'b0;
    run(8'h41, 8'h40, 16'h0005, 5, 1, 16'h6004);
    err_arm = 1'b1;
    run(8'h40, 8'h40, 16'h0005, 5, -1, 16'h6010);
    err_arm = 1'b0;
    lba = 48'hA1B2_C3D4_E5F6;
    run(8'h01, 8'h40, 16'h0006, 6, 2, 16'h4104);
    lba = lba + 48'h2;
    #1;
    chk("err lba low", eb, lba[23:0]);
    high_order_byte_select_in = 1'b1;
    #1;
    chk("err lba high", eb, lba[47:24]);
    high_order_byte_select_in = 1'b0;
    run(8'h95, 8'h40, 16'h0003, 3, -1, 16'h4000);
    run(8'h43, 8'h00, 16'h0000, 2, -1, 16'h6001);
    span = t1 - t0;
    chk("limit span", 1'(span >= 30000 && span <= 30080), 1'b1);
    timing_unit_in = 32'h0000_0001;
    run(8'h40, 8'h01, 16'h0000, 2, -1, 16'h6001);
    span = t1 - t0;
    chk("min span", 1'(span >= 25000 && span <= 25080), 1'b1);
    // a slow host on an unconfigured stream must not run into a limit
    gap = 26000;
    run(8'h06, 8'h00, 16'h0002, 2, -1, 16'h4000);
    final_report();
  end

  initial begin
    #(40 * 90000);
    errors++;
    final_report();
  end
endmodule : swc_ctrl_tb
`default_nettype wire
